// ---- common/i2cm_cfg.svh ----
// timing and encoding constants for the two-wire bus master
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
`define I2CM_CLK_MHZ 100
`define I2CM_SCL_QTR_CYC 250
`define I2CM_HOLD_LONG_NS 300
`define I2CM_HOLD_LONG_CYC ((`I2CM_HOLD_LONG_NS * `I2CM_CLK_MHZ + 999) / 1000)
`define I2CM_HOLD_SHORT_CYC 1
`define I2CM_CNT_W 16
`define I2CM_ACK_BIT 4'h8
`define I2CM_PIN_LOW 1'b0
`define I2CM_RELEASE 1'b1
`define I2CM_BYTE_RST 8'h00
`define I2CM_CNT_RST 16'h0000
`define I2CM_BIT_RST 4'h0
`endif

// ---- common/i2cm_pkg.sv ----
// types shared by the two-wire bus master
`include "i2cm_cfg.svh"
package i2cm_pkg;
   typedef logic [`I2CM_CNT_W-1:0] i2cm_cnt_type;
   // gray codes along idle, setup, start, park, low, high
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_STRT = 3'h3,
      ST_PARK = 3'h2,
      ST_LOW = 3'h6,
      ST_HIGH = 3'h7,
      ST_LOST = 3'h5
   } i2cm_state_type;
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ = 2'h2,
      OP_STOP = 2'h3
   } i2cm_op_type;
   typedef struct packed {
      i2cm_op_type op;
      logic [7:0] data;
      logic ack_n;
   } i2cm_cmd_type;
   typedef struct packed {
      logic [7:0] data;
      logic nack;
      logic lost;
      logic coll;
      logic err;
   } i2cm_rsp_type;
   typedef struct packed {
      i2cm_state_type st;
      i2cm_cnt_type cnt;
      logic [3:0] bit_cnt;
      i2cm_op_type op;
      logic [7:0] shift;
      logic ack_n;
      logic scl_oe_n;
      logic sda_oe_n;
      logic scl_m;
      logic scl_s;
      logic sda_m;
      logic sda_s;
      logic scl_p;
      logic sda_p;
      logic low_seen;
      logic busy;
      logic cmd_ready;
      logic rsp_valid;
      i2cm_rsp_type rsp;
   } i2cm_regs_type;
endpackage

// ---- hw/i2cm_master.sv ----
// two-wire bus master: start/stop, byte framing, arbitration, collision
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_master #(
   parameter int QTR_CYC = `I2CM_SCL_QTR_CYC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic LONG_HOLD_SELECT,
   input wire logic CMD_VALID,
   input wire i2cm_pkg::i2cm_cmd_type CMD,
   output logic CMD_READY,
   output logic RSP_VALID,
   output i2cm_pkg::i2cm_rsp_type RSP,
   output logic BUS_BUSY,
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE_N,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N
);
   localparam i2cm_pkg::i2cm_cnt_type HALF = i2cm_pkg::i2cm_cnt_type'(2 * QTR_CYC);
   localparam i2cm_pkg::i2cm_cnt_type HOLD_LONG =
      i2cm_pkg::i2cm_cnt_type'(`I2CM_HOLD_LONG_CYC);
   localparam i2cm_pkg::i2cm_cnt_type HOLD_SHORT =
      i2cm_pkg::i2cm_cnt_type'(`I2CM_HOLD_SHORT_CYC);

   i2cm_pkg::i2cm_regs_type q;
   i2cm_pkg::i2cm_regs_type d;
   logic accept;
   logic start_det;
   logic stop_det;
   logic tx_now;
   logic bit_now;
   i2cm_pkg::i2cm_cnt_type hold;

   // level this master puts on data for the current bit; 1 means released
   function automatic logic cur_bit(input i2cm_pkg::i2cm_op_type op,
                                    input logic [3:0] bc,
                                    input logic [7:0] sh,
                                    input logic an);
      logic b;
      b = `I2CM_RELEASE;
      unique case (op)
         i2cm_pkg::OP_WRITE: b = (bc < `I2CM_ACK_BIT) ? sh[7] : `I2CM_RELEASE;
         i2cm_pkg::OP_READ: b = (bc < `I2CM_ACK_BIT) ? `I2CM_RELEASE : an;
         i2cm_pkg::OP_STOP: b = `I2CM_PIN_LOW;
         i2cm_pkg::OP_START: b = `I2CM_RELEASE;
      endcase
      return b;
   endfunction

   // whether this master is the transmitter of the current bit
   function automatic logic is_tx(input i2cm_pkg::i2cm_op_type op,
                                  input logic [3:0] bc);
      logic t;
      t = 1'b0;
      unique case (op)
         i2cm_pkg::OP_WRITE: t = (bc < `I2CM_ACK_BIT);
         i2cm_pkg::OP_READ: t = (bc == `I2CM_ACK_BIT);
         i2cm_pkg::OP_STOP: t = 1'b0;
         i2cm_pkg::OP_START: t = 1'b1;
      endcase
      return t;
   endfunction

   // bus condition decode on synchronised lines
   // start detect
   assign start_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   // stop detect; needs clock low first
   assign stop_det = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s & q.low_seen;
   assign accept = CMD_VALID & q.cmd_ready;
   assign tx_now = is_tx(q.op, q.bit_cnt);
   assign bit_now = cur_bit(q.op, q.bit_cnt, q.shift, q.ack_n);
   // long hold when selected; short default
   // a long hold must stay below HALF or the bit loses its setup time
   assign hold = LONG_HOLD_SELECT ? HOLD_LONG : HOLD_SHORT;

   // next-state logic for the whole master
   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      // three flops per pin; first stage feeds only the second
      d.scl_m = SCL_I;
      d.scl_s = q.scl_m;
      d.sda_m = SDA_I;
      d.sda_s = q.sda_m;
      d.scl_p = q.scl_s;
      d.sda_p = q.sda_s;
      if (start_det) begin
         d.low_seen = 1'b0;
      end else if (!q.scl_s) begin
         d.low_seen = 1'b1;
      end
      if (start_det) begin
         d.busy = 1'b1;
      end else if (stop_det) begin
         d.busy = 1'b0;
      end
      unique case (q.st)
         i2cm_pkg::ST_IDLE: begin
            d.scl_oe_n = `I2CM_RELEASE;
            d.sda_oe_n = `I2CM_RELEASE;
            if (accept) begin
               d.cnt = `I2CM_CNT_RST;
               if (CMD.op == i2cm_pkg::OP_START) begin
                  d.st = i2cm_pkg::ST_SETUP;
               end else begin
                  // no bus owned: anything but start is refused
                  d.rsp_valid = 1'b1;
                  d.rsp = '0;
                  d.rsp.err = 1'b1;
               end
            end
         end
         i2cm_pkg::ST_SETUP: begin
            d.cnt = q.cnt + 1'b1;
            // data already low before we drive it
            // a low clock counts too: someone else already owns the bus
            if (!q.sda_s || !q.scl_s) begin
               d.rsp_valid = 1'b1;
               d.rsp = '0;
               d.rsp.coll = 1'b1;
               d.st = i2cm_pkg::ST_LOST;
            end else if (q.cnt == HALF) begin
               d.cnt = `I2CM_CNT_RST;
               d.sda_oe_n = `I2CM_PIN_LOW;
               d.st = i2cm_pkg::ST_STRT;
            end
         end
         i2cm_pkg::ST_STRT: begin
            // data low with clock high, then clock low
            d.sda_oe_n = `I2CM_PIN_LOW;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == HALF) begin
               d.scl_oe_n = `I2CM_PIN_LOW;
               d.st = i2cm_pkg::ST_PARK;
               d.rsp_valid = 1'b1;
               d.rsp = '0;
            end
         end
         i2cm_pkg::ST_PARK: begin
            // bus owned, clock held low until the next command
            d.scl_oe_n = `I2CM_PIN_LOW;
            if (accept) begin
               d.op = CMD.op;
               d.shift = CMD.data;
               d.ack_n = CMD.ack_n;
               d.bit_cnt = `I2CM_BIT_RST;
               d.cnt = `I2CM_CNT_RST;
               d.st = i2cm_pkg::ST_LOW;
            end
         end
         i2cm_pkg::ST_LOW: begin
            // change data only while clock is low
            d.scl_oe_n = `I2CM_PIN_LOW;
            d.cnt = q.cnt + 1'b1;
            // ack slot releases data on a write; on a read it puts ack_n on data
            if (q.cnt == hold) begin
               d.sda_oe_n = bit_now;
            end
            if (q.cnt == HALF) begin
               d.cnt = `I2CM_CNT_RST;
               d.scl_oe_n = `I2CM_RELEASE;
               d.st = i2cm_pkg::ST_HIGH;
            end
         end
         i2cm_pkg::ST_HIGH: begin
            // stretched clock: count starts only once the line is high
            if (q.scl_s || q.cnt != `I2CM_CNT_RST) begin
               d.cnt = q.cnt + 1'b1;
            end
            // sample on rise; msb first into the shifter
            if (q.scl_s && q.cnt == `I2CM_CNT_RST && q.bit_cnt < `I2CM_ACK_BIT) begin
               d.shift = {q.shift[6:0], q.sda_s};
            end
            if (q.scl_s && q.cnt == `I2CM_CNT_RST && q.bit_cnt == `I2CM_ACK_BIT) begin
               d.rsp.nack = q.sda_s;
            end
            // mismatch loses; wired-and compare; collision
            // compare the enable really on the pin: after the first high sample
            // the shifter already holds the next bit
            if (q.scl_s && tx_now && q.sda_oe_n && !q.sda_s) begin
               // release clock as well, then wait for stop
               d.scl_oe_n = `I2CM_RELEASE;
               d.sda_oe_n = `I2CM_RELEASE;
               d.rsp_valid = 1'b1;
               d.rsp = '0;
               d.rsp.data = q.shift;
               d.rsp.lost = 1'b1;
               d.rsp.coll = 1'b1;
               d.st = i2cm_pkg::ST_LOST;
            end else if (q.cnt == HALF) begin
               d.cnt = `I2CM_CNT_RST;
               unique case (q.op)
                  i2cm_pkg::OP_STOP: begin
                     d.sda_oe_n = `I2CM_RELEASE;
                     d.st = i2cm_pkg::ST_IDLE;
                     d.rsp_valid = 1'b1;
                     d.rsp = '0;
                  end
                  i2cm_pkg::OP_START: begin
                     // repeated start from a released-high data line
                     d.sda_oe_n = `I2CM_PIN_LOW;
                     d.st = i2cm_pkg::ST_STRT;
                  end
                  default: begin
                     d.scl_oe_n = `I2CM_PIN_LOW;
                     // nine pulses: eight data plus ack
                     if (q.bit_cnt == `I2CM_ACK_BIT) begin
                        // read bytes repeat until stop or restart
                        d.st = i2cm_pkg::ST_PARK;
                        d.rsp_valid = 1'b1;
                        d.rsp.data = q.shift;
                        d.rsp.lost = 1'b0;
                        d.rsp.coll = 1'b0;
                        d.rsp.err = 1'b0;
                     end else begin
                        d.bit_cnt = q.bit_cnt + 1'b1;
                        d.st = i2cm_pkg::ST_LOW;
                     end
                  end
               endcase
            end
         end
         i2cm_pkg::ST_LOST: begin
            // hands off, retry only after a stop
            d.scl_oe_n = `I2CM_RELEASE;
            d.sda_oe_n = `I2CM_RELEASE;
            if (stop_det) begin
               d.st = i2cm_pkg::ST_IDLE;
            end
         end
         default: begin
            d.st = i2cm_pkg::ST_IDLE;
         end
      endcase
      // idle only when unowned and both lines high
      // ready drops the cycle after an accept so a held request is not taken twice
      d.cmd_ready = ((d.st == i2cm_pkg::ST_IDLE) && !d.busy && d.scl_s && d.sda_s)
                    || ((d.st == i2cm_pkg::ST_PARK) && !(q.st == i2cm_pkg::ST_PARK && accept));
      if (accept) begin
         d.cmd_ready = 1'b0;
      end
   end

   // single state register; pins reset released and high
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         q <= '0;
         q.st <= i2cm_pkg::ST_IDLE;
         q.op <= i2cm_pkg::OP_START;
         q.scl_oe_n <= `I2CM_RELEASE;
         q.sda_oe_n <= `I2CM_RELEASE;
         q.scl_m <= 1'b1;
         q.scl_s <= 1'b1;
         q.sda_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // open drain: driven value is always zero
   assign SCL_O = `I2CM_PIN_LOW;
   assign SDA_O = `I2CM_PIN_LOW;
   assign SCL_OE_N = q.scl_oe_n;
   assign SDA_OE_N = q.sda_oe_n;
   assign CMD_READY = q.cmd_ready;
   assign RSP_VALID = q.rsp_valid;
   assign RSP = q.rsp;
   assign BUS_BUSY = q.busy;
endmodule

// ---- sim/i2cm_checker.sv ----
// concurrent checks on the two-wire master ports
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_checker (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic LONG_HOLD_SELECT,
   input wire logic CMD_VALID,
   input wire i2cm_pkg::i2cm_cmd_type CMD,
   input wire logic CMD_READY,
   input wire logic RSP_VALID,
   input wire i2cm_pkg::i2cm_rsp_type RSP,
   input wire logic BUS_BUSY,
   input wire logic SCL_O,
   input wire logic SCL_OE_N,
   input wire logic SDA_O,
   input wire logic SDA_OE_N
);
   localparam logic [7:0] HOLD_L = 8'(`I2CM_HOLD_LONG_CYC - 1);
   localparam logic [7:0] HOLD_S = 8'(`I2CM_HOLD_SHORT_CYC - 1);
   logic [7:0] low_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // cycles our clock pull has lasted; saturates so a long park cannot wrap
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) low_q <= 8'h00;
      else if (SCL_OE_N) low_q <= 8'h00;
      else if (low_q != 8'hff) low_q <= low_q + 8'h01;
   end
   a_pins_zero: assert property (!SCL_O && !SDA_O)
      else $error("pin output value not zero");
   a_data_hold: assert property ($changed(SDA_OE_N) && !SCL_OE_N && !$past(SCL_OE_N) |->
      low_q >= (LONG_HOLD_SELECT ? HOLD_L : HOLD_S)) else $error("data moved inside hold");
   a_ready_drop: assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
      else $error("ready stayed high after accept");
   a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
      else $error("response longer than one cycle");
   a_idle_err: assert property (CMD_VALID && CMD_READY && !BUS_BUSY &&
      CMD.op != i2cm_pkg::OP_START |-> ##[1:2] RSP_VALID && RSP.err) else $error("no idle error");
   a_ready_own: assert property (CMD_READY && BUS_BUSY |-> !SCL_OE_N)
      else $error("ready on a bus we do not hold");
   a_lost_free: assert property (RSP_VALID && RSP.lost |-> SDA_OE_N && SCL_OE_N)
      else $error("lines still pulled after loss");
   a_start_high: assert property ($fell(SDA_OE_N) && SCL_OE_N |-> SCL_OE_N [*8])
      else $error("clock pulled too soon after start");
   a_stop_idle: assert property ($rose(SDA_OE_N) && SCL_OE_N && $past(SCL_OE_N) |->
      ##[1:12] !BUS_BUSY) else $error("stop not seen as idle");
endmodule
bind i2cm_master i2cm_checker i_chk (.CLK(CLK), .RESET(RESET), .LONG_HOLD_SELECT(LONG_HOLD_SELECT),
   .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP(RSP),
   .BUS_BUSY(BUS_BUSY), .SCL_O(SCL_O), .SCL_OE_N(SCL_OE_N), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N));

// ---- sim/i2cm_slave_model.sv ----
// behavioural slave: acks its own address and written bytes, sends a fixed read byte
`timescale 1ns/1ps
module i2cm_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a,
   parameter logic [7:0] TX = 8'ha5
) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe_n = 1'b1,
   output logic [7:0] rx_byte = 8'h00
);
   logic [3:0] n = 4'h0;
   logic [7:0] sh = 8'h00;
   logic sel = 1'b0;
   logic rd = 1'b0;
   logic first = 1'b0;
   logic scl_p = 1'b1;
   logic sda_p = 1'b1;
   // one process owns all model state; edges found against the last levels
   always @(scl or sda) begin
      if (scl && scl_p && sda_p && !sda) begin
         n = 4'h0;
         first = 1'b1;
         sel = 1'b0;
         sda_oe_n = 1'b1;
      end else if (scl && scl_p && !sda_p && sda) begin
         sel = 1'b0;
         sda_oe_n = 1'b1;
      end else if (scl && !scl_p) begin
         // sample rising, nine pulses, nack ends read
         if (n < 4'h8) sh = {sh[6:0], sda};
         if (n == 4'h8 && rd && !first && sda) sel = 1'b0;
         n = n + 4'h1;
      end else if (!scl && scl_p) begin
         // change 100 ns into the low phase; ack own address and written bytes
         #100;
         if (n == 4'h8) begin
            if (first) begin
               sel = (sh[7:1] == ADDR);
               rd = sh[0];
            end else if (sel && !rd) rx_byte = sh;
            sda_oe_n = !(sel && (first || !rd));
            first = 1'b0;
         end else begin
            if (n == 4'h9) n = 4'h0;
            sda_oe_n = (sel && rd && !first) ? TX[3'h7 - n[2:0]] : 1'b1;
         end
      end
      scl_p = scl;
      sda_p = sda;
   end
endmodule

// ---- sim/i2cm_master_tb_top.sv ----
// self-checking bench: master against a slave model and a rival on the bus
`timescale 1ns/1ps
module i2cm_master_tb_top;
   localparam logic [6:0] ADDR = 7'h2a;
   localparam logic [7:0] TX = 8'ha5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hold_sel = 1'b0;
   logic cmd_valid = 1'b0;
   i2cm_pkg::i2cm_cmd_type cmd = '0;
   i2cm_pkg::i2cm_rsp_type rsp_o, rsp;
   logic cmd_ready, rsp_valid, busy, scl_oe_n, sda_oe_n, slv_oe_n;
   logic [7:0] rx_byte;
   logic tb_scl_n = 1'b1;
   logic tb_sda_n = 1'b1;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   // pulled-up wires: low when any party pulls
   wire scl = scl_oe_n & tb_scl_n;
   wire sda = sda_oe_n & slv_oe_n & tb_sda_n;
   always #5 clk = ~clk;
   i2cm_master #(.QTR_CYC(40)) i_dut (.CLK(clk), .RESET(rst), .LONG_HOLD_SELECT(hold_sel),
      .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
      .RSP(rsp_o), .BUS_BUSY(busy), .SCL_I(scl), .SCL_O(), .SCL_OE_N(scl_oe_n),
      .SDA_I(sda), .SDA_O(), .SDA_OE_N(sda_oe_n));
   i2cm_slave_model #(.ADDR(ADDR), .TX(TX)) i_slv (.scl(scl), .sda(sda),
      .sda_oe_n(slv_oe_n), .rx_byte(rx_byte));
   task automatic conclude();
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one command, held until accepted, then wait for its single response
   task automatic issue(input logic [1:0] op, input logic [7:0] d = 8'h00, input logic an = 1'b1);
      int k;
      wt(1);
      for (k = 0; cmd_ready !== 1'b1 && k < 5000; k++) wt(1);
      cmd_valid = 1'b1;
      cmd = '{i2cm_pkg::i2cm_op_type'(op), d, an};
      wt(1);
      cmd_valid = 1'b0;
      for (k = 0; rsp_valid !== 1'b1 && k < 5000; k++) wt(1);
      check({11'h000, k == 5000}, 12'h000);
      rsp = rsp_o;
   endtask
   // rival makes a stop after leaving the data line low
   task automatic bus_stop();
      tb_scl_n = 1'b0;
      wt(100);
      tb_sda_n = 1'b0;
      wt(100);
      tb_scl_n = 1'b1;
      wt(100);
      tb_sda_n = 1'b1;
      wt(100);
   endtask
   task automatic t_write();
      issue(2'h0);
      check(rsp, 12'h000);
      issue(2'h1, {ADDR, 1'b0});
      check(rsp, {ADDR, 1'b0, 4'h0});
      issue(2'h1, 8'h3c);
      check(rsp, 12'h3c0);
      issue(2'h3);
      wt(20);
      check({4'h0, rx_byte}, 12'h03c);
      check({11'h000, busy}, 12'h000);
   endtask
   task automatic t_read();
      issue(2'h0);
      issue(2'h1, {ADDR, 1'b1});
      check(rsp, {ADDR, 1'b1, 4'h0});
      issue(2'h2, 8'h00, 1'b0);
      check(rsp, {TX, 4'h0});
      issue(2'h2);
      check(rsp, {TX, 4'h8});
      issue(2'h3);
      wt(20);
      check({11'h000, busy}, 12'h000);
   endtask
   task automatic t_idle_err();
      issue(2'h1, 8'h55);
      check({9'h000, rsp.lost, rsp.coll, rsp.err}, 12'h001);
   endtask
   // rival pulls data low while the clock is parked, as if sending a lower address
   task automatic t_arb();
      issue(2'h0);
      tb_sda_n = 1'b0;
      issue(2'h1, 8'hff);
      check({9'h000, rsp.lost, rsp.coll, rsp.err}, 12'h006);
      check({10'h000, scl_oe_n, sda_oe_n}, 12'h003);
      wt(50);
      check({11'h000, cmd_ready}, 12'h000);
      bus_stop();
      check({11'h000, cmd_ready}, 12'h001);
   endtask
   // rival grabs the data line during our start setup
   task automatic t_coll();
      fork
         issue(2'h0);
         begin
            wt(10);
            tb_sda_n = 1'b0;
         end
      join
      check({9'h000, rsp.lost, rsp.coll, rsp.err}, 12'h002);
      bus_stop();
      check({11'h000, cmd_ready}, 12'h001);
   endtask
   initial begin
      wt(20);
      rst = 1'b0;
      wt(5);
      // short hold first, then long hold
      for (int h = 0; h < 2; h++) begin
         hold_sel = h[0];
         t_write();
         t_read();
      end
      t_idle_err();
      t_arb();
      t_coll();
      conclude();
   end
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         conclude();
      end
   end
endmodule
